// ### hdl/charge_sequencer.sv
// Purpose: charge phase sequencer with status pin, Avalon-MM registers and interrupt
// Assumes: analog comparator levels arrive asynchronously; 20 MHz reference clock
// Notes:   converter loops and detection timing live in the analog section
// Summary of operation
// [R1] status pin pulled low while a charge cycle runs
// [R2] status pin released when charge is done or the charger is disabled
// [R3] any fault sends one 128 us pulse on the status pin
// [R4] status enable bit in control gates all status pin signalling
// [R5] charge runs conditioning, then constant current, then constant voltage
// [R6] below short-battery threshold the fixed wake current is applied
// [R7] above short-battery threshold the programmed charge current is used
// [R8] regulation voltage programmable from 3.5 V to 4.44 V
// [R9] low current in voltage phase above recharge level ends charge, starts detection
// [R10] detection finding a battery moves to charge done
// [R11] termination current level is programmable by the host
// [R12] termination enable at 0 stops low-current termination
// [R13] switching converter runs at a fixed 1.5 MHz
// [R14] recharge dip, supply toggle, disable toggle, reset bit or hi-z toggle restart charge
// [R15] disable bit at 1 holds charging off; writing 0 starts a cycle
`include "charger_cfg.svh"
module charge_sequencer (
   // clock and reset
   input  wire logic        ref_clk,
   input  wire logic        reset,
   // avalon-mm slave
   input  wire logic [7:0]  avs_address,
   input  wire logic        avs_read,
   input  wire logic        avs_write,
   input  wire logic [31:0] avs_writedata,
   output logic      [31:0] avs_readdata,
   output logic             avs_waitrequest,
   // analog comparator levels
   input  wire logic        supply_valid,
   input  wire logic        bat_below_short,
   input  wire logic        bat_at_regulation,
   input  wire logic        bat_below_recharge,
   input  wire logic        current_below_term,
   input  wire logic        battery_present,
   input  wire logic        fault_in,
   // charger controls
   output logic             charge_fet_on,
   output logic             short_battery_wake_current,
   output logic      [3:0]  charge_current_code,
   output logic      [5:0]  battery_regulation_voltage,
   output logic      [2:0]  termination_current_code,
   output logic             converter_clk,
   // open-drain status pin
   output logic             stat_out,
   output logic             stat_oe,
   // interrupt
   output logic             irq
);
   localparam int SW_STEP = `SW_FREQ_KHZ * 2;

   logic [6:0]                s_q;
   logic                      sup_q, short_q, atreg_q, rch_q, term_q, pres_q, flt_q;
   logic                      sup_d_r, flt_d_r;
   logic [4:0]                ctrl_r;
   logic [5:0]                vreg_r;
   logic [6:0]                cur_r;
   logic [2:0]                irq_stat_r;
   logic [2:0]                irq_mask_r;
   logic                      wait_r;
   logic                      ack;
   logic                      wr_ctrl;
   logic [4:0]                ctrl_nxt;
   logic                      restart;
   logic                      enabled;
   logic                      enabled_nxt;
   logic                      charging;
   logic [2:0]                events;
   logic [31:0]               rd_mux;
   logic [15:0]               sw_acc_r;
   charger_pkg::phase_t       phase_r, phase_nxt;
   pulse_if                   pif ();

   sync2 #(.WIDTH(7)) u_sync (
      .ref_clk (ref_clk),
      .reset   (reset),
      .d       ({supply_valid, bat_below_short, bat_at_regulation, bat_below_recharge,
                 current_below_term, battery_present, fault_in}),
      .q       (s_q)
   );
   assign {sup_q, short_q, atreg_q, rch_q, term_q, pres_q, flt_q} = s_q;

   stat_pulse u_pulse (
      .ref_clk (ref_clk),
      .reset   (reset),
      .p       (pif.timer)
   );

   // bus handshake: one wait cycle, then a single acknowledge cycle
   assign ack = (avs_read || avs_write) && !wait_r;

   always_ff @(posedge ref_clk) begin
      if (reset) begin
         wait_r <= 1'b1;
      end else begin
         wait_r <= !((avs_read || avs_write) && wait_r);
      end
   end
   assign avs_waitrequest = wait_r;

   always_comb begin
      rd_mux = 32'h0000_0000;
      unique case (avs_address)
         `OFS_CTRL:     rd_mux = {27'h0, ctrl_r};
         `OFS_VREG:     rd_mux = {26'h0, vreg_r};
         `OFS_CURRENT:  rd_mux = {25'h0, cur_r};
         `OFS_STATUS:   rd_mux = {24'h0, pif.active, sup_q, phase_r};
         `OFS_IRQ_STAT: rd_mux = {29'h0, irq_stat_r};
         `OFS_IRQ_MASK: rd_mux = {29'h0, irq_mask_r};
         default:       rd_mux = 32'h0000_0000;
      endcase
   end

   always_ff @(posedge ref_clk) begin
      if (reset) begin
         avs_readdata <= 32'h0000_0000;
      end else if (avs_read && wait_r) begin
         avs_readdata <= rd_mux;
      end
   end

   assign wr_ctrl = ack && avs_write && avs_address == `OFS_CTRL;

   // reset bit is self-clearing: it only fires the restart
   always_comb begin
      ctrl_nxt = ctrl_r;
      ctrl_nxt[`CTRL_RESET] = 1'b0;
      if (wr_ctrl) begin
         ctrl_nxt = avs_writedata[4:0];
      end
   end

   always_ff @(posedge ref_clk) begin
      if (reset) begin
         ctrl_r <= `CTRL_RESET_VAL;
      end else begin
         ctrl_r <= ctrl_nxt;
      end
   end

   always_ff @(posedge ref_clk) begin
      if (reset) begin
         vreg_r <= `VREG_RESET_VAL;
         cur_r  <= `CURRENT_RESET_VAL;
      end else if (ack && avs_write) begin
         if (avs_address == `OFS_VREG) begin
            // codes past the top of the range clamp to 4.44 V
            vreg_r <= (avs_writedata[5:0] > `VREG_MAX_CODE) ? `VREG_MAX_CODE
                                                            : avs_writedata[5:0]; // R8
         end
         if (avs_address == `OFS_CURRENT) begin
            cur_r <= avs_writedata[6:0]; // R11
         end
      end
   end

   // delayed levels for restart and fault edges
   always_ff @(posedge ref_clk) begin
      if (reset) begin
         sup_d_r <= 1'b0;
         flt_d_r <= 1'b0;
      end else begin
         sup_d_r <= sup_q;
         flt_d_r <= flt_q;
      end
   end

   assign enabled  = sup_q && !ctrl_r[`CTRL_CHG_DIS] && !ctrl_r[`CTRL_HIZ]; // R15
   // judged on the value being written, so enable and disable act without a lag
   assign enabled_nxt = sup_q && !ctrl_nxt[`CTRL_CHG_DIS] && !ctrl_nxt[`CTRL_HIZ]; // R15
   assign restart  = (sup_q != sup_d_r)
                  || (ctrl_nxt[`CTRL_CHG_DIS] != ctrl_r[`CTRL_CHG_DIS])
                  || (wr_ctrl && avs_writedata[`CTRL_RESET])
                  || (ctrl_nxt[`CTRL_HIZ] != ctrl_r[`CTRL_HIZ])
                  || (phase_r == charger_pkg::PH_DONE && rch_q); // R14
   assign charging = phase_r inside {charger_pkg::PH_COND, charger_pkg::PH_CC,
                                     charger_pkg::PH_CV};

   always_comb begin
      phase_nxt = phase_r;
      unique case (phase_r)
         charger_pkg::PH_IDLE:   phase_nxt = charger_pkg::PH_IDLE;
         charger_pkg::PH_COND:   if (!short_q) phase_nxt = charger_pkg::PH_CC; // R5
         charger_pkg::PH_CC:     if (atreg_q) phase_nxt = charger_pkg::PH_CV; // R5
         charger_pkg::PH_CV:     if (ctrl_r[`CTRL_TERM_EN] && term_q && !rch_q)
                                    phase_nxt = charger_pkg::PH_DETECT; // R9 R12
         charger_pkg::PH_DETECT: if (pres_q) phase_nxt = charger_pkg::PH_DONE; // R10
         charger_pkg::PH_DONE:   phase_nxt = charger_pkg::PH_DONE;
         default:                phase_nxt = charger_pkg::PH_IDLE;
      endcase
      if (restart || !enabled_nxt) begin
         phase_nxt = enabled_nxt ? charger_pkg::PH_COND : charger_pkg::PH_IDLE; // R14 R15
      end
   end

   always_ff @(posedge ref_clk) begin
      if (reset) begin
         phase_r <= charger_pkg::PH_IDLE;
      end else begin
         phase_r <= phase_nxt;
      end
   end

   // power stage controls, registered so the pins never glitch
   always_ff @(posedge ref_clk) begin
      if (reset) begin
         charge_fet_on              <= 1'b0;
         short_battery_wake_current <= 1'b0;
         charge_current_code        <= 4'h0;
         battery_regulation_voltage <= `VREG_RESET_VAL;
         termination_current_code   <= 3'h0;
      end else begin
         charge_fet_on              <= phase_nxt inside {charger_pkg::PH_COND,
                                       charger_pkg::PH_CC, charger_pkg::PH_CV}; // R9
         short_battery_wake_current <= phase_nxt == charger_pkg::PH_COND; // R6
         charge_current_code        <= (phase_nxt inside {charger_pkg::PH_CC,
                                        charger_pkg::PH_CV}) ? cur_r[3:0] : 4'h0; // R7
         battery_regulation_voltage <= vreg_r; // R8
         termination_current_code   <= cur_r[6:4]; // R11
      end
   end

   // 1.5 MHz from 20 MHz: fractional accumulator toggles at twice the rate
   always_ff @(posedge ref_clk) begin
      if (reset) begin
         sw_acc_r      <= 16'h0000;
         converter_clk <= 1'b0;
      end else if (!sup_q || ctrl_r[`CTRL_HIZ]) begin
         sw_acc_r      <= 16'h0000;
         converter_clk <= 1'b0;
      end else if (sw_acc_r + 16'(SW_STEP) >= 16'(`CLK_FREQ_KHZ)) begin
         sw_acc_r      <= sw_acc_r + 16'(SW_STEP) - 16'(`CLK_FREQ_KHZ); // R13
         converter_clk <= !converter_clk; // R13
      end else begin
         sw_acc_r <= sw_acc_r + 16'(SW_STEP);
      end
   end

   // interrupt events; supply arrival is also reported on the pin
   assign events[`IRQ_FAULT]  = flt_q && !flt_d_r;
   assign events[`IRQ_DONE]   = phase_nxt == charger_pkg::PH_DONE
                             && phase_r != charger_pkg::PH_DONE;
   assign events[`IRQ_SUPPLY] = sup_q && !sup_d_r;
   assign pif.trig            = events[`IRQ_FAULT] || events[`IRQ_SUPPLY]; // R3

   always_ff @(posedge ref_clk) begin
      if (reset) begin
         irq_stat_r <= 3'h0;
      end else if (ack && avs_write && avs_address == `OFS_IRQ_STAT) begin
         // a new event wins over a clear in the same cycle
         irq_stat_r <= (irq_stat_r & ~avs_writedata[2:0]) | events;
      end else begin
         irq_stat_r <= irq_stat_r | events;
      end
   end

   always_ff @(posedge ref_clk) begin
      if (reset) begin
         irq_mask_r <= 3'h0;
         irq        <= 1'b0;
      end else begin
         if (ack && avs_write && avs_address == `OFS_IRQ_MASK) begin
            irq_mask_r <= avs_writedata[2:0];
         end
         irq <= |(irq_stat_r & irq_mask_r);
      end
   end

   // open-drain pin: pulse inverts the charging level so it shows in either state
   always_ff @(posedge ref_clk) begin
      if (reset) begin
         stat_out <= 1'b0;
         stat_oe  <= 1'b0;
      end else begin
         stat_out <= 1'b0;
         // a charger losing its supply releases the pin on the same edge as its phase falls back
         stat_oe  <= ctrl_r[`CTRL_STAT_EN]
                     && ((charging && enabled) ^ pif.active); // R1 R2 R3 R4
      end
   end

   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (reset);

   a_stat_charging : assert property (charging && enabled && !pif.active // R1
      && ctrl_r[`CTRL_STAT_EN] |=> stat_oe)
      else $error("status not driven low during charge");
   a_stat_release : assert property ((phase_r == charger_pkg::PH_DONE || !enabled)
      && !pif.active |=> !stat_oe) // R2
      else $error("status driven while done or disabled");
   a_stat_gated : assert property (!ctrl_r[`CTRL_STAT_EN] |=> !stat_oe) // R4
      else $error("status driven while disabled by control");
   a_phase_order : assert property (phase_r == charger_pkg::PH_CC && !restart && enabled
      |=> phase_r inside {charger_pkg::PH_CC, charger_pkg::PH_CV}) // R5
      else $error("constant current left out of order");
   a_wake_current : assert property (phase_r == charger_pkg::PH_COND && short_q // R6
      && !restart && enabled |=> short_battery_wake_current)
      else $error("wake current missing below short threshold");
   a_prog_current : assert property (phase_nxt == charger_pkg::PH_CC
      |=> charge_current_code == $past(cur_r[3:0])) // R7
      else $error("programmed current not applied");
   a_vreg_range : assert property (vreg_r <= `VREG_MAX_CODE) // R8
      else $error("regulation code out of range");
   a_terminate : assert property (phase_r == charger_pkg::PH_CV && term_q && !rch_q
      && ctrl_r[`CTRL_TERM_EN] && !restart && enabled
      |=> phase_r == charger_pkg::PH_DETECT ##1 !charge_fet_on) // R9
      else $error("termination did not start detection");
   a_no_term : assert property (!ctrl_r[`CTRL_TERM_EN] |-> phase_nxt != charger_pkg::PH_DETECT
      || phase_r == charger_pkg::PH_DETECT) // R12
      else $error("terminated while termination disabled");
   a_done_entry : assert property (phase_r == charger_pkg::PH_DETECT && pres_q
      && !restart && enabled |=> phase_r == charger_pkg::PH_DONE) // R10
      else $error("detected battery did not reach done");
   a_restart : assert property (enabled && wr_ctrl && avs_writedata[`CTRL_RESET]
      && !avs_writedata[`CTRL_HIZ] && !avs_writedata[`CTRL_CHG_DIS]
      |=> phase_r == charger_pkg::PH_COND) // R14
      else $error("reset bit did not restart charge");
   a_disable_hold : assert property (ctrl_nxt[`CTRL_CHG_DIS] // R15
      |=> phase_r == charger_pkg::PH_IDLE)
      else $error("charging while disabled");
   a_sw_toggle : assert property ($changed(converter_clk) // R13
      |=> (!$changed(converter_clk) || $past(!sup_q || ctrl_r[`CTRL_HIZ])) [*5])
      else $error("converter clock faster than 1.5 MHz");
   a_fault_pulse : assert property (events[`IRQ_FAULT] |=> pif.active) // R3
      else $error("fault gave no status pulse");
   a_detect_hold : assert property (phase_r == charger_pkg::PH_DETECT // R10
      && !pres_q && !restart && enabled |=> phase_r == charger_pkg::PH_DETECT)
      else $error("detection left without a battery");
   a_wake_off : assert property (phase_nxt == charger_pkg::PH_CC // R7
      |=> !short_battery_wake_current)
      else $error("wake current left on in constant current");
   a_idle_fet_off : assert property (phase_r == charger_pkg::PH_IDLE // R15
      |-> !charge_fet_on)
      else $error("charge transistor on while idle");

   c_full_charge : cover property (phase_r == charger_pkg::PH_CV
      ##[1:1000] phase_r == charger_pkg::PH_DONE);
   c_fault_pulse : cover property (events[`IRQ_FAULT] ##1 stat_oe != charging);
   c_irq_clear   : cover property (irq ##[1:50] !irq);
   c_recharge    : cover property (phase_r == charger_pkg::PH_DONE && rch_q
      ##1 phase_r == charger_pkg::PH_COND);
   c_restart_bit : cover property (wr_ctrl && avs_writedata[`CTRL_RESET]
      ##1 phase_r == charger_pkg::PH_COND);
endmodule

// ### hdl/charger_cfg.svh
// Purpose: offsets, field positions, reset values and timing counts of the sequencer
// Assumes: 20 MHz reference clock
// Notes:   included by the design files and the bench
`ifndef CHARGER_CFG_SVH
`define CHARGER_CFG_SVH

`define CLK_PERIOD_NS     50
`define STAT_PULSE_NS     128000
`define STAT_PULSE_CYC    ((`STAT_PULSE_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define CLK_FREQ_KHZ      20000
`define SW_FREQ_KHZ       1500

`define OFS_CTRL          8'h00
`define OFS_VREG          8'h04
`define OFS_CURRENT       8'h08
`define OFS_STATUS        8'h0C
`define OFS_IRQ_STAT      8'h10
`define OFS_IRQ_MASK      8'h14

`define CTRL_STAT_EN      0
`define CTRL_CHG_DIS      1
`define CTRL_TERM_EN      2
`define CTRL_RESET        3
`define CTRL_HIZ          4
`define CTRL_RESET_VAL    5'h05

`define VREG_MAX_CODE     6'h2F
`define VREG_RESET_VAL    6'h05
`define ICHG_LSB          0
`define ITERM_LSB         4
`define CURRENT_RESET_VAL 7'h23

`define IRQ_FAULT         0
`define IRQ_DONE          1
`define IRQ_SUPPLY        2

`endif

// ### hdl/charger_pkg.sv
// Purpose: types shared by the charge sequencer modules
// Assumes: nothing
// Notes:   phase codes are one-hot
package charger_pkg;
   typedef enum logic [5:0] {
      PH_IDLE   = 6'h01,
      PH_COND   = 6'h02,
      PH_CC     = 6'h04,
      PH_CV     = 6'h08,
      PH_DETECT = 6'h10,
      PH_DONE   = 6'h20
   } phase_t;
endpackage

// ### hdl/pulse_if.sv
// Purpose: trigger and busy flag between sequencer and status pulse timer
// Assumes: one clock domain
// Notes:   trig is a one-cycle request
interface pulse_if;
   logic trig;
   logic active;
   modport requester (output trig, input active);
   modport timer     (input trig, output active);
endinterface

// ### hdl/sync2.sv
// Purpose: two-stage synchroniser for a bus of independent levels
// Assumes: each bit is a slow level, no word coherence needed
// Notes:   first stage feeds only the second
module sync2 #(
   parameter int WIDTH = 8
) (
   // clock and reset
   input  wire logic             ref_clk,
   input  wire logic             reset,
   // levels
   input  wire logic [WIDTH-1:0] d,
   output logic      [WIDTH-1:0] q
);
   logic [WIDTH-1:0] meta_r;

   always_ff @(posedge ref_clk) begin
      if (reset) begin
         meta_r <= '0;
         q      <= '0;
      end else begin
         meta_r <= d;
         q      <= meta_r;
      end
   end
endmodule

// ### hdl/stat_pulse.sv
// Purpose: fixed-length interrupt pulse for the status pin
// Assumes: 20 MHz clock
// Notes:   a trigger during a running pulse restarts it
`include "charger_cfg.svh"
module stat_pulse #(
   parameter int PULSE_CYC = `STAT_PULSE_CYC
) (
   // clock and reset
   input  wire logic ref_clk,
   input  wire logic reset,
   // request
   pulse_if.timer    p
);
   logic [15:0] cnt_r;
   logic [15:0] len_r;

   always_ff @(posedge ref_clk) begin
      if (reset) begin
         cnt_r    <= 16'h0000;
         p.active <= 1'b0;
      end else if (p.trig) begin
         cnt_r    <= 16'(PULSE_CYC - 1);
         p.active <= 1'b1; // R3
      end else if (cnt_r != 16'h0000) begin
         cnt_r <= cnt_r - 16'h0001;
      end else begin
         p.active <= 1'b0;
      end
   end

   // cycles the pulse has stood since its last trigger, for the upper bound only
   always_ff @(posedge ref_clk) begin
      if (reset || p.trig || !p.active) begin
         len_r <= 16'h0000;
      end else begin
         len_r <= len_r + 16'h0001;
      end
   end

   a_pulse_length : assert property (@(posedge ref_clk) disable iff (reset) // R3
      $rose(p.active) && !p.trig [*1] ##1 !p.trig [*3] |-> p.active)
      else $error("status pulse ended too early");
   a_pulse_bound : assert property (@(posedge ref_clk) disable iff (reset) // R3
      len_r <= 16'(PULSE_CYC))
      else $error("status pulse outlasted its length");
endmodule

// ### dv/battery_model.sv
// Purpose: cell and status pull-up standing at the charger's far side
// Assumes: one charge step every 64 cycles while the charge transistor conducts
// Notes:   dip drops the cell to a level below the recharge point
module battery_model (
   // clock and reset
   input  wire logic ref_clk,
   input  wire logic reset,
   // charger side
   input  wire logic charge_fet_on,
   input  wire logic dip,
   input  wire logic stat_out,
   input  wire logic stat_oe,
   // comparator levels
   output logic      bat_below_short,
   output logic      bat_at_regulation,
   output logic      bat_below_recharge,
   output logic      current_below_term,
   // pin as the host sees it
   output wire       stat_line
);
   logic [3:0] level_r;
   logic [5:0] tick_r;

   always_ff @(posedge ref_clk) begin
      if (reset) begin
         level_r <= 4'h0;
         tick_r  <= 6'h00;
      end else if (dip) begin
         level_r <= 4'h8;
      end else if (charge_fet_on) begin
         tick_r <= tick_r + 6'h01;
         if (tick_r == 6'h3F && level_r != 4'hF)
            level_r <= level_r + 4'h1;
      end
   end

   // current tapers only near the top, so termination lags regulation
   assign bat_below_short    = level_r < 4'h4;
   assign bat_at_regulation  = level_r >= 4'hC;
   assign bat_below_recharge = level_r < 4'hA;
   assign current_below_term = level_r >= 4'hE;
   // external pull-up: a released pin reads high
   assign stat_line = stat_oe ? stat_out : 1'b1;
endmodule

// ### dv/charge_sequencer_tb.sv
// Purpose: self-checking bench for the charge sequencer
// Assumes: battery_model stands in for the cell and the pull-up
// Notes:   status pulse runs at its full 2560 cycles
`include "charger_cfg.svh"
module charge_sequencer_tb;
   timeunit 1ns;
   timeprecision 1ns;
   logic        ref_clk = 1'b0;
   logic        reset = 1'b1;
   logic [7:0]  avs_address = 8'h00;
   logic        avs_read = 1'b0;
   logic        avs_write = 1'b0;
   logic [31:0] avs_writedata = 32'h0;
   logic        supply_valid = 1'b0;
   logic        fault_in = 1'b0;
   logic        battery_present = 1'b0;
   logic        dip = 1'b0;
   logic [31:0] avs_readdata;
   logic        avs_waitrequest, bat_below_short, bat_at_regulation, bat_below_recharge;
   logic        current_below_term, charge_fet_on, short_battery_wake_current;
   logic        converter_clk, stat_out, stat_oe, irq;
   logic [3:0]  charge_current_code;
   logic [5:0]  battery_regulation_voltage;
   logic [2:0]  termination_current_code;
   wire         stat_line;
   int          error_cnt = 0;
   int          compares = 0;

   always #25 ref_clk = ~ref_clk;

   charge_sequencer charge_sequencer_i (.ref_clk, .reset, .avs_address, .avs_read, .avs_write,
      .avs_writedata, .avs_readdata, .avs_waitrequest, .supply_valid, .bat_below_short,
      .bat_at_regulation, .bat_below_recharge, .current_below_term, .battery_present,
      .fault_in, .charge_fet_on, .short_battery_wake_current, .charge_current_code,
      .battery_regulation_voltage, .termination_current_code, .converter_clk, .stat_out,
      .stat_oe, .irq);
   battery_model battery_model_i (.ref_clk, .reset, .charge_fet_on, .dip, .stat_out, .stat_oe,
      .bat_below_short, .bat_at_regulation, .bat_below_recharge, .current_below_term,
      .stat_line);

   task automatic finish_test();
      if (error_cnt == 0 && compares > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask

   task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
      compares++;
      if (got !== exp) begin
         error_cnt++;
         $display("Error %s expected %h seen %h", what, exp, got);
      end
   endtask

   task automatic hang(input string what);
      error_cnt++;
      $display("Error %s expected response seen timeout", what);
      finish_test();
   endtask

   // request held until waitrequest is seen low at a rising edge
   task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d,
                      output logic [31:0] q);
      int n;
      @(posedge ref_clk);
      avs_address   <= a;
      avs_writedata <= d;
      avs_write     <= wr;
      avs_read      <= !wr;
      n = 0;
      do begin
         @(posedge ref_clk);
         n++;
      end while (avs_waitrequest !== 1'b0 && n < 20);
      q = avs_readdata;
      avs_write <= 1'b0;
      avs_read  <= 1'b0;
      if (avs_waitrequest !== 1'b0)
         hang("waitrequest");
   endtask

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic [31:0] q;
      bus(1'b1, a, d, q);
   endtask

   task automatic rd_chk(input string what, input logic [7:0] a, input logic [31:0] exp);
      logic [31:0] q;
      bus(1'b0, a, 32'h0, q);
      chk(what, exp, q);
   endtask

   task automatic wait_phase(input logic [5:0] ph);
      logic [31:0] q;
      int n;
      n = 0;
      do begin
         bus(1'b0, `OFS_STATUS, 32'h0, q);
         n++;
      end while (q[5:0] !== ph && n < 3000);
      if (q[5:0] !== ph)
         hang("phase");
   endtask

   task automatic wait_fet();
      int n;
      n = 0;
      while (charge_fet_on !== 1'b1 && n < 200) begin
         @(negedge ref_clk);
         n++;
      end
      if (charge_fet_on !== 1'b1)
         hang("charge_fet_on");
   endtask

   task automatic settle();
      repeat (4) @(negedge ref_clk);
   endtask

   // counts cycles with the pin released while a fault is raised for 5 cycles
   task automatic fault_shot(output int rel_cnt);
      rel_cnt = 0;
      @(posedge ref_clk);
      fault_in <= 1'b1;
      for (int i = 0; i < 2700; i++) begin
         @(posedge ref_clk);
         if (stat_line === 1'b1)
            rel_cnt++;
         if (i == 4)
            fault_in <= 1'b0;
      end
   endtask

   task automatic t_registers();
      rd_chk("ctrl", `OFS_CTRL, 32'h05);
      rd_chk("vreg", `OFS_VREG, 32'h05);
      rd_chk("current", `OFS_CURRENT, 32'h23);
      rd_chk("irq_mask", `OFS_IRQ_MASK, 32'h00);
      wr(8'h18, 32'hFF);
      rd_chk("unmapped", 8'h18, 32'h00);
      wr(`OFS_VREG, 32'h3F);
      rd_chk("vreg clamp", `OFS_VREG, 32'h2F);
      settle();
      chk("regulation code", 32'h2F, battery_regulation_voltage);
      wr(`OFS_VREG, 32'h00);
      wr(`OFS_CURRENT, 32'h5A);
      settle();
      chk("regulation low", 32'h00, battery_regulation_voltage);
      chk("term code", 32'h5, termination_current_code);
      wr(`OFS_CTRL, 32'h01);
   endtask

   task automatic t_charge();
      int tog;
      logic last;
      @(posedge ref_clk);
      supply_valid <= 1'b1;
      wait_phase(charger_pkg::PH_COND);
      chk("wake current", 32'h1, short_battery_wake_current);
      chk("cond code", 32'h0, charge_current_code);
      chk("pin during pulse", 32'h1, stat_line);
      wait_phase(charger_pkg::PH_CC);
      settle();
      chk("wake off", 32'h0, short_battery_wake_current);
      chk("cc code", 32'hA, charge_current_code);
      wait_phase(charger_pkg::PH_CV);
      tog = 0;
      last = converter_clk;
      repeat (2000) begin
         @(negedge ref_clk);
         if (converter_clk !== last)
            tog++;
         last = converter_clk;
      end
      chk("converter toggles", 32'd300, (tog >= 299 && tog <= 301) ? 300 : tog);
      repeat (1500) @(negedge ref_clk);
      chk("pin charging", 32'h0, stat_line);
      rd_chk("no termination", `OFS_STATUS, 32'h48);
      rd_chk("supply event", `OFS_IRQ_STAT, 32'h04);
   endtask

   task automatic t_fault();
      int rel;
      wr(`OFS_IRQ_STAT, 32'h07);
      wr(`OFS_IRQ_MASK, 32'h01);
      fault_shot(rel);
      chk("fault pulse cycles", 32'd2560, rel);
      chk("irq raised", 32'h1, irq);
      wr(`OFS_IRQ_STAT, 32'h01);
      settle();
      chk("irq cleared", 32'h0, irq);
      wr(`OFS_IRQ_MASK, 32'h00);
      wr(`OFS_CTRL, 32'h00);
      settle();
      chk("pin disabled", 32'h1, stat_line);
      fault_shot(rel);
      chk("disabled pulse", 32'd2700, rel);
      chk("irq masked", 32'h0, irq);
      rd_chk("fault sticky", `OFS_IRQ_STAT, 32'h01);
      wr(`OFS_IRQ_STAT, 32'h01);
   endtask

   task automatic t_terminate();
      wr(`OFS_CTRL, 32'h05);
      wait_phase(charger_pkg::PH_DETECT);
      settle();
      chk("fet off", 32'h0, charge_fet_on);
      repeat (100) @(negedge ref_clk);
      rd_chk("no battery yet", `OFS_STATUS, 32'h50);
      @(posedge ref_clk);
      battery_present <= 1'b1;
      wait_phase(charger_pkg::PH_DONE);
      settle();
      chk("pin done", 32'h1, stat_line);
      rd_chk("done event", `OFS_IRQ_STAT, 32'h02);
   endtask

   task automatic t_restart();
      @(posedge ref_clk);
      dip <= 1'b1;
      @(posedge ref_clk);
      dip <= 1'b0;
      wait_fet();
      wait_phase(charger_pkg::PH_DONE);
      wr(`OFS_CTRL, 32'h07);
      settle();
      rd_chk("held off", `OFS_STATUS, 32'h41);
      chk("pin disabled off", 32'h1, stat_line);
      wr(`OFS_CTRL, 32'h05);
      wait_fet();
      wait_phase(charger_pkg::PH_DONE);
      wr(`OFS_CTRL, 32'h0D);
      wait_fet();
      rd_chk("reset self clears", `OFS_CTRL, 32'h05);
      wait_phase(charger_pkg::PH_DONE);
      wr(`OFS_CTRL, 32'h15);
      settle();
      chk("hiz converter", 32'h0, converter_clk);
      wr(`OFS_CTRL, 32'h05);
      wait_fet();
      wait_phase(charger_pkg::PH_DONE);
      @(posedge ref_clk);
      supply_valid <= 1'b0;
      wait_phase(charger_pkg::PH_IDLE);
      @(posedge ref_clk);
      supply_valid <= 1'b1;
      wait_fet();
   endtask

   initial begin
      repeat (4) @(posedge ref_clk);
      reset <= 1'b0;
      t_registers();
      t_charge();
      t_fault();
      t_terminate();
      t_restart();
      finish_test();
   end
endmodule
